// [src/pswd_consts.vh]
// constants for the power-state and watchdog control block
// assumes a 50 MHz system clock and an AXI4-Lite register bus
`ifndef PSWD_CONSTS_VH
`define PSWD_CONSTS_VH
// register indices and byte addresses
`define PSWD_IDX_RESET_ID 16'h0000
`define PSWD_IDX_PWR_STATE 16'h4003
`define PSWD_IDX_WDOG 16'h4004
`define PSWD_IDX_RESET_CFG 16'h4006
`define PSWD_ADDR_RESET_ID 18'h0_0000
`define PSWD_ADDR_PWR_STATE 18'h1_000C
`define PSWD_ADDR_WDOG 18'h1_0010
`define PSWD_ADDR_RESET_CFG 18'h1_0018
`define PSWD_ADDR_INPUTS 18'h1_0100
// power state field positions
`define PSWD_ON_BIT 15
`define PSWD_SLP_BIT 14
`define PSWD_REFLP_BIT 12
`define PSWD_DLY_HI 11
`define PSWD_DLY_LO 10
`define PSWD_SRDLY_BIT 9
// watchdog field positions and the reset-config scope bit
`define PSWD_WEN_BIT 15
`define PSWD_WPAUSE_BIT 14
`define PSWD_WSRC_BIT 13
`define PSWD_WSLP_BIT 12
`define PSWD_WKICK_BIT 11
`define PSWD_SEC_HI 9
`define PSWD_SEC_LO 8
`define PSWD_PRI_HI 5
`define PSWD_PRI_LO 4
`define PSWD_PER_HI 2
`define PSWD_PER_LO 0
`define PSWD_SCOPE_BIT 10
// reset values
`define PSWD_PWR_RESET 16'h0800
`define PSWD_WATCHDOG_SOFTWARE_KICK 16'hA207
`define PSWD_PRI_RESET 2'h0
`define PSWD_SCOPE_RESET 1'b1
// action codes
`define PSWD_ACT_NONE 2'h0
`define PSWD_ACT_IRQ 2'h1
`define PSWD_ACT_RESET 2'h2
`define PSWD_ACT_WAKE 2'h3
// timing: delays in microseconds, base period in microseconds
`define PSWD_CLK_MHZ 50
`define PSWD_DLY1_US 1000
`define PSWD_DLY10_US 10000
`define PSWD_WD_BASE_US 256000
// axi responses
`define PSWD_RESP_OKAY 2'h0
`define PSWD_RESP_SLVERR 2'h2
`endif

// [src/pswd_ctrl.v]
// power-state command and watchdog control registers with axi4-lite slave
// assumes sequencer, key and hardware kick come from the same clock domain
//
// The implementer's own choice: register access over AXI4-Lite.
`include "pswd_consts.vh"

// Function
// (RL1) on-status bit 15 reports ON, resets 0
// (RL2) writing 0 to on-status starts OFF
// (RL3) writing 1 to on-status starts nothing
// (RL4) sleep-status bit 14 reports SLEEP, resets 0
// (RL5) writing 0 to sleep-status starts WAKE
// (RL6) writing 1 to sleep-status starts SLEEP
// (RL7) bit 12 selects low-power reference mode
// (RL8) bits 11:10 select transition delay 0/1ms/10ms
// (RL9) bit 9 delays software reset by delay
// (RL10) watchdog enable bit 15, resets 1, no restart
// (RL11) pause bit 14 freezes watchdog count
// (RL12) source bit 13: hardware or software kick
// (RL13) sleep-enable bit 12 gates watchdog in SLEEP
// (RL14) software kick bit 11 restarts if software source
// (RL15) primary action bits 5:4 on timeout
// (RL16) secondary action bits 9:8, resets device reset
// (RL17) period bits 2:0; secondary after two periods
// (RL18) protected fields writable only when key unlocked
// (RL19) any write to address zero: software reset
// (RL20) scope bit chooses whether map is cleared
// (RL21) restart reloads period, clears pending stages
// (RL22) locked key leaves protected fields unchanged
module pswd_ctrl #(
  parameter BASE_CYCLES = `PSWD_WD_BASE_US * `PSWD_CLK_MHZ,
  parameter DLY1_CYCLES = `PSWD_DLY1_US * `PSWD_CLK_MHZ,
  parameter DLY10_CYCLES = `PSWD_DLY10_US * `PSWD_CLK_MHZ,
  parameter [15:0] CHIP_ID = 16'h5A5A
)(
  input wire i_sys_clk,
  input wire i_resetn,
  input wire [17:0] i_awaddr,
  input wire i_awvalid,
  output reg o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [17:0] i_araddr,
  input wire i_arvalid,
  output reg o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  input wire i_sys_on,
  input wire i_sys_sleep,
  input wire i_key_unlocked,
  input wire i_hw_kick,
  output reg o_off_req,
  output reg o_sleep_req,
  output reg o_wake_req,
  output reg o_lowpower_reference_select,
  output reg o_soft_reset,
  output reg o_soft_reset_clear_map,
  output reg o_wdog_irq,
  output reg o_wdog_device_reset
);

  reg aw_held;
  reg w_held;
  reg [17:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg lowpower_reference_select;
  reg [1:0] transition_delay_select;
  reg soft_reset_delay_enable;
  reg watchdog_enable_bit;
  reg watchdog_pause;
  reg watchdog_kick_source;
  reg watchdog_sleep_enable;
  reg [1:0] watchdog_secondary_action;
  reg [1:0] watchdog_primary_action;
  reg [2:0] watchdog_period_select;
  reg soft_reset_scope_select;
  reg [36:0] wd_count;
  reg wd_primary_done;
  reg sr_pending;
  reg [31:0] sr_count;
  reg [31:0] rd_word;
  reg [31:0] next_sr_load;
  wire wr_go;
  wire lo_ok;
  wire hi_ok;
  wire wd_running;
  wire kick;
  wire wd_expire;
  wire [36:0] period_cycles;

  // cycles of the selected watchdog period
  function [36:0] period_len;
    input [2:0] sel;
    begin
      period_len = {5'h00, BASE_CYCLES[31:0]} << sel;
    end
  endfunction

  // cycles of the selected transition delay
  function [31:0] delay_len;
    input [1:0] sel;
    begin
      case (sel)
        2'h2: delay_len = DLY1_CYCLES;
        2'h3: delay_len = DLY10_CYCLES;
        default: delay_len = 32'h0000_0000;
      endcase
    end
  endfunction

  assign wr_go = aw_held && w_held && !o_bvalid;
  assign lo_ok = w_strb[0];
  assign hi_ok = w_strb[1];
  assign period_cycles = period_len(watchdog_period_select);
  assign wd_running = watchdog_enable_bit && !watchdog_pause &&
                      (!i_sys_sleep || watchdog_sleep_enable); // see (RL10) see (RL11) see (RL13)
  // software kick only when software source, hardware only otherwise
  assign kick = watchdog_kick_source ?
                (wr_go && aw_addr == `PSWD_ADDR_WDOG && hi_ok && w_data[`PSWD_WKICK_BIT]) :
                i_hw_kick; // see (RL12) see (RL14)
  assign wd_expire = wd_running && (wd_count + 37'h1 >= period_cycles);

  always @*
  begin
    next_sr_load = soft_reset_delay_enable ? delay_len(transition_delay_select) :
                   32'h0000_0000; // see (RL9)
  end

  always @*
  begin
    case (i_araddr)
      `PSWD_ADDR_RESET_ID: rd_word = {16'h0000, CHIP_ID};
      `PSWD_ADDR_PWR_STATE: rd_word = {16'h0000, i_sys_on, i_sys_sleep, 1'b0,
        lowpower_reference_select, transition_delay_select, soft_reset_delay_enable,
        9'h000}; // see (RL1) see (RL4)
      `PSWD_ADDR_WDOG: rd_word = {16'h0000, watchdog_enable_bit, watchdog_pause,
        watchdog_kick_source, watchdog_sleep_enable, 2'h0, watchdog_secondary_action,
        2'h0, watchdog_primary_action, 1'b0, watchdog_period_select};
      `PSWD_ADDR_RESET_CFG: rd_word = {21'h00_0000, soft_reset_scope_select, 10'h000};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // write channel capture and response
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 18'h0_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `PSWD_RESP_OKAY;
    end
    else
    begin
      o_awready <= !aw_held && !o_awready && !o_bvalid;
      o_wready <= !w_held && !o_wready && !o_bvalid;
      if (i_awvalid && o_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (wr_go)
      begin
        o_bvalid <= 1'b1;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        case (aw_addr)
          `PSWD_ADDR_RESET_ID, `PSWD_ADDR_PWR_STATE, `PSWD_ADDR_WDOG,
          `PSWD_ADDR_RESET_CFG: o_bresp <= `PSWD_RESP_OKAY;
          default: o_bresp <= `PSWD_RESP_SLVERR;
        endcase
      end
      else if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
    end
  end

  // read channel
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `PSWD_RESP_OKAY;
    end
    else
    begin
      o_arready <= !o_arready && !o_rvalid && i_arvalid;
      if (i_arvalid && o_arready)
      begin
        o_rvalid <= 1'b1;
        o_rdata <= rd_word;
        case (i_araddr)
          `PSWD_ADDR_RESET_ID, `PSWD_ADDR_PWR_STATE, `PSWD_ADDR_WDOG,
          `PSWD_ADDR_RESET_CFG: o_rresp <= `PSWD_RESP_OKAY;
          default: o_rresp <= `PSWD_RESP_SLVERR;
        endcase
      end
      else if (o_rvalid && i_rready)
        o_rvalid <= 1'b0;
    end
  end

  // registers, commands and software reset
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      lowpower_reference_select <= 1'b0;
      transition_delay_select <= 2'h2;
      soft_reset_delay_enable <= 1'b0;
      watchdog_enable_bit <= 1'b1;
      watchdog_pause <= 1'b0;
      watchdog_kick_source <= 1'b1;
      watchdog_sleep_enable <= 1'b0;
      watchdog_secondary_action <= `PSWD_ACT_RESET;
      watchdog_primary_action <= `PSWD_PRI_RESET;
      watchdog_period_select <= 3'h7;
      soft_reset_scope_select <= `PSWD_SCOPE_RESET;
      o_off_req <= 1'b0;
      o_sleep_req <= 1'b0;
      o_wake_req <= 1'b0;
      o_lowpower_reference_select <= 1'b0;
      o_soft_reset <= 1'b0;
      o_soft_reset_clear_map <= 1'b0;
      sr_pending <= 1'b0;
      sr_count <= 32'h0000_0000;
    end
    else
    begin
      o_off_req <= 1'b0;
      o_sleep_req <= 1'b0;
      o_wake_req <= wd_expire && (wd_primary_done ?
                    watchdog_secondary_action : watchdog_primary_action) == `PSWD_ACT_WAKE;
      o_soft_reset <= 1'b0;
      o_lowpower_reference_select <= lowpower_reference_select; // see (RL7)
      if (sr_pending)
      begin
        if (sr_count == 32'h0000_0000)
        begin
          sr_pending <= 1'b0;
          o_soft_reset <= 1'b1; // see (RL19)
          o_soft_reset_clear_map <= !soft_reset_scope_select; // see (RL20)
          if (!soft_reset_scope_select)
          begin
            lowpower_reference_select <= 1'b0;
            transition_delay_select <= 2'h2;
            soft_reset_delay_enable <= 1'b0;
            watchdog_enable_bit <= 1'b1;
            watchdog_pause <= 1'b0;
            watchdog_kick_source <= 1'b1;
            watchdog_sleep_enable <= 1'b0;
            watchdog_secondary_action <= `PSWD_ACT_RESET;
            watchdog_primary_action <= `PSWD_PRI_RESET;
            watchdog_period_select <= 3'h7;
          end
        end
        else
          sr_count <= sr_count - 32'h0000_0001;
      end
      if (wr_go)
      begin
        case (aw_addr)
          `PSWD_ADDR_RESET_ID:
          begin
            sr_pending <= 1'b1;
            sr_count <= next_sr_load; // see (RL19)
          end
          `PSWD_ADDR_PWR_STATE:
          begin
            if (hi_ok)
            begin
              lowpower_reference_select <= w_data[`PSWD_REFLP_BIT];
              transition_delay_select <= w_data[`PSWD_DLY_HI:`PSWD_DLY_LO]; // see (RL8)
              soft_reset_delay_enable <= w_data[`PSWD_SRDLY_BIT];
              o_off_req <= !w_data[`PSWD_ON_BIT]; // see (RL2) see (RL3)
              o_sleep_req <= w_data[`PSWD_SLP_BIT]; // see (RL6)
              if (!w_data[`PSWD_SLP_BIT])
                o_wake_req <= 1'b1; // see (RL5)
            end
          end
          `PSWD_ADDR_WDOG:
          begin
            if (i_key_unlocked) // see (RL18) see (RL22)
            begin
              if (hi_ok)
              begin
                watchdog_enable_bit <= w_data[`PSWD_WEN_BIT];
                watchdog_pause <= w_data[`PSWD_WPAUSE_BIT];
                watchdog_kick_source <= w_data[`PSWD_WSRC_BIT];
                watchdog_sleep_enable <= w_data[`PSWD_WSLP_BIT];
                watchdog_secondary_action <= w_data[`PSWD_SEC_HI:`PSWD_SEC_LO]; // see (RL16)
              end
              if (lo_ok)
              begin
                watchdog_primary_action <= w_data[`PSWD_PRI_HI:`PSWD_PRI_LO]; // see (RL15)
                watchdog_period_select <= w_data[`PSWD_PER_HI:`PSWD_PER_LO]; // see (RL17)
              end
            end
          end
          `PSWD_ADDR_RESET_CFG:
          begin
            if (i_key_unlocked && hi_ok)
              soft_reset_scope_select <= w_data[`PSWD_SCOPE_BIT]; // see (RL20)
          end
          default:
          begin
            sr_pending <= sr_pending;
          end
        endcase
      end
    end
  end

  // watchdog counter and two-stage actions
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wd_count <= 37'h0_0000_0000;
      wd_primary_done <= 1'b0;
      o_wdog_irq <= 1'b0;
      o_wdog_device_reset <= 1'b0;
    end
    else
    begin
      o_wdog_irq <= 1'b0;
      o_wdog_device_reset <= 1'b0;
      if (kick)
      begin
        wd_count <= 37'h0_0000_0000; // see (RL21)
        wd_primary_done <= 1'b0;
      end
      else if (wd_expire)
      begin
        wd_count <= 37'h0_0000_0000;
        wd_primary_done <= !wd_primary_done; // see (RL17)
        case (wd_primary_done ? watchdog_secondary_action : watchdog_primary_action)
          `PSWD_ACT_IRQ: o_wdog_irq <= 1'b1; // see (RL15) see (RL16)
          `PSWD_ACT_RESET: o_wdog_device_reset <= 1'b1;
          default: o_wdog_irq <= 1'b0;
        endcase
      end
      else if (wd_running)
        wd_count <= wd_count + 37'h0_0000_0001;
    end
  end

endmodule // pswd_ctrl

// [dv/pswd_checker.sv]
// checker: bus and command relations of the power-state and watchdog block
// assumes the top module's ports; bound at the foot
module pswd_checker (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_arvalid,
  input wire o_arready,
  input wire o_rvalid,
  input wire i_rready,
  input wire [31:0] o_rdata,
  input wire o_bvalid,
  input wire i_bready,
  input wire o_off_req,
  input wire o_sleep_req,
  input wire o_wake_req,
  input wire o_lowpower_reference_select,
  input wire o_soft_reset,
  input wire o_wdog_irq,
  input wire o_wdog_device_reset
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_off_cause: assert property (o_off_req |-> $rose(o_bvalid))
    else $error("off pulse without write");
  a_sleep_cause: assert property (o_sleep_req |-> $rose(o_bvalid))
    else $error("sleep pulse without write");
  a_sleep_wake_excl: assert property (!(o_sleep_req && o_wake_req))
    else $error("sleep and wake together");
  a_irq_pulse: assert property (o_wdog_irq |=> !o_wdog_irq)
    else $error("irq longer than one cycle");
  a_devrst_pulse: assert property (o_wdog_device_reset |=> !o_wdog_device_reset)
    else $error("device reset longer than one cycle");
  a_swrst_pulse: assert property (o_soft_reset |=> !o_soft_reset)
    else $error("soft reset longer than one cycle");
  a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  a_resp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped early");
  a_lpref_cause: assert property ($changed(o_lowpower_reference_select)
    |-> $past(o_bvalid) || $past(o_soft_reset))
    else $error("reference select changed without write");
endmodule // pswd_checker

bind pswd_ctrl pswd_checker u_chk (.*);

// [dv/power_state_and_watchdog_ctrl_tb_top.sv]
// testbench: register bus driver, read scoreboard and pulse counters
// assumes the block with short watchdog and delay counts
`include "pswd_consts.vh"
module power_state_and_watchdog_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 0, i_resetn = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic i_arvalid = 0, i_rready = 0, i_sys_on = 0, i_sys_sleep = 0;
  logic i_key_unlocked = 1, i_hw_kick = 0;
  logic [17:0] i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0;
  logic [3:0] i_wstrb = 4'h3;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_off_req, o_sleep_req;
  wire o_wake_req, o_lowpower_reference_select, o_soft_reset, o_soft_reset_clear_map;
  wire o_wdog_irq, o_wdog_device_reset;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  int fail_count = 0, tests_run = 0, n_off = 0, n_slp = 0, n_wak = 0;
  int n_irq = 0, n_dev = 0, n_sr = 0, per, t, d;
  logic [31:0] exp_q[$];
  logic [1:0] resp;
  logic [15:0] cfg[4] = '{16'hE810, 16'hA810, 16'h2810, 16'hB810};
  pswd_ctrl #(.BASE_CYCLES(16), .DLY1_CYCLES(5), .DLY10_CYCLES(12), .CHIP_ID(16'h1234)) dut (.*);
  always #10 i_sys_clk = ~i_sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // pulse counters and read scoreboard
  always @(posedge i_sys_clk)
  begin
    n_off += o_off_req;
    n_slp += o_sleep_req;
    n_wak += o_wake_req;
    n_irq += o_wdog_irq;
    n_dev += o_wdog_device_reset;
    n_sr += o_soft_reset;
    if (o_rvalid && i_rready)
    begin
      chk(o_rdata, exp_q.pop_front());
      chk(o_rresp, `PSWD_RESP_OKAY);
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task wr(input logic [17:0] a, input logic [31:0] dat);
    i_awaddr <= a;
    i_wdata <= dat;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    do
    begin
      @(posedge i_sys_clk);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
    end
    while (!o_bvalid);
    resp = o_bresp;
    i_bready <= 0;
    cyc(1);
  endtask
  task rd(input logic [17:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_araddr <= a;
    i_arvalid <= 1;
    i_rready <= 1;
    do
    begin
      @(posedge i_sys_clk);
      if (o_arready) i_arvalid <= 0;
    end
    while (!o_rvalid);
    i_rready <= 0;
    cyc(1);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #300_000;
    fail_count++;
    conclude;
  end
  initial
  begin
    void'($urandom(32'h1491));
    cyc(10);
    i_resetn <= 1;
    cyc(2);
    rd(`PSWD_ADDR_PWR_STATE, 32'h0000_0800);
    rd(`PSWD_ADDR_WDOG, 32'h0000_A207);
    rd(`PSWD_ADDR_RESET_ID, 32'h0000_1234);
    wr(18'h0_0040, 32'h0000_0000);
    chk(resp, `PSWD_RESP_SLVERR);
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      i_sys_on <= i[1];
      i_sys_sleep <= i[0];
      cyc(2);
      rd(`PSWD_ADDR_PWR_STATE, {16'h0, i[1], i[0], 14'h0800});
    end
    i_sys_on <= 0;
    i_sys_sleep <= 0;
    wr(`PSWD_ADDR_PWR_STATE, 32'h0000_5800);
    cyc(2);
    chk(n_off, 1);
    chk(n_slp, 1);
    chk(o_lowpower_reference_select, 1);
    wr(`PSWD_ADDR_PWR_STATE, 32'h0000_8800);
    cyc(2);
    chk(n_off, 1);
    chk(n_wak, 1);
    i_key_unlocked <= 0;
    wr(`PSWD_ADDR_WDOG, 32'h0000_0000);
    rd(`PSWD_ADDR_WDOG, 32'h0000_A207);
    i_key_unlocked <= 1;
    $display("test commands done");
    per = $urandom % 3;
    t = 16 << per;
    // primary code i, secondary code 3-i
    for (int i = 0; i < 4; i++)
    begin
      n_irq = 0;
      n_dev = 0;
      n_wak = 0;
      wr(`PSWD_ADDR_WDOG, 32'h0000_A800 | (i << 4) | ((3 - i) << 8) | per);
      cyc(t - 6);
      chk(n_irq + n_dev + n_wak, 0);
      cyc(t + 12);
      chk(n_irq, (i == 1) + (i == 2));
      chk(n_dev, (i == 1) + (i == 2));
      chk(n_wak, (i == 0) + (i == 3));
    end
    // pause, sleep gating, disabled, sleep with enable
    for (int j = 0; j < 4; j++)
    begin
      i_sys_sleep <= j[0];
      n_irq = 0;
      wr(`PSWD_ADDR_WDOG, {16'h0, cfg[j]} | per);
      cyc(t + 6);
      chk(n_irq, j == 3);
    end
    i_sys_sleep <= 0;
    wr(`PSWD_ADDR_WDOG, 32'h0000_A810 | per);
    wr(`PSWD_ADDR_WDOG, 32'h0000_8010 | per);
    n_irq = 0;
    repeat (4)
    begin
      i_hw_kick <= 1;
      cyc(1);
      i_hw_kick <= 0;
      cyc(t / 2 - 1);
    end
    chk(n_irq, 0);
    cyc(t + 6);
    chk(n_irq, 1);
    $display("test watchdog done");
    for (int s = 0; s < 4; s++)
    begin
      if (s == 1) continue;
      d = (s == 2) ? 5 : (s == 3) ? 12 : 0;
      wr(`PSWD_ADDR_PWR_STATE, 32'h0000_8200 | (s << 10));
      n_sr = 0;
      wr(`PSWD_ADDR_RESET_ID, 32'h0000_0000);
      cyc(2);
      chk(n_sr, d == 0);
      cyc(d + 6);
      chk(n_sr, 1);
    end
    rd(`PSWD_ADDR_PWR_STATE, 32'h0000_0E00);
    chk(o_soft_reset_clear_map, 0);
    wr(`PSWD_ADDR_RESET_CFG, 32'h0000_0000);
    wr(`PSWD_ADDR_RESET_ID, 32'h0000_0000);
    cyc(20);
    rd(`PSWD_ADDR_PWR_STATE, 32'h0000_0800);
    rd(`PSWD_ADDR_WDOG, 32'h0000_A207);
    chk(o_soft_reset_clear_map, 1);
    $display("test soft reset done");
    conclude;
  end
endmodule // power_state_and_watchdog_ctrl_tb_top
